// File: inc/tlip_pkg.sv
// Shared constants and types for the two-level interrupt prioritizer
package tlip_pkg;

	// ****************************************************************
	// Register port geometry and map
	// ****************************************************************
	localparam int          DATA_W        = 8;
	localparam int          ADDR_W        = 4;
	localparam int          PC_W          = 16;
	localparam int          VNUM_W        = 8;

	localparam logic [3:0]  OFS_CTL_A     = 4'h0;
	localparam logic [3:0]  OFS_STATUS    = 4'h1;
	localparam logic [3:0]  OFS_LVL0PRI   = 4'h2;
	localparam logic [3:0]  OFS_HPVEC     = 4'h3;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int          CTL_A_RR_BIT      = 0;
	localparam int          CTL_A_COMPACT_BIT = 5;
	localparam int          CTL_A_SECT_BIT    = 6;
	localparam int          STAT_LVL0_BIT   = 0;
	localparam int          STAT_LVL1_BIT   = 1;
	localparam int          STAT_NMI_BIT    = 7;

	localparam logic [7:0]  CTL_A_RST     = 8'h00;
	localparam logic [7:0]  STATUS_RST    = 8'h00;
	localparam logic [7:0]  HPVEC_RST     = 8'h00;
	localparam logic [7:0]  RDATA_IDLE    = 8'h00;

	// ****************************************************************
	// Vector numbering and placement
	// ****************************************************************
	localparam logic [7:0]  VEC_NMI       = 8'h00;
	localparam logic [7:0]  VEC_FIRST     = 8'h01;
	localparam logic [7:0]  CVT_SLOT_NMI  = 8'h00;
	localparam logic [7:0]  CVT_SLOT_LVL1 = 8'h01;
	localparam logic [7:0]  CVT_SLOT_LVL0 = 8'h02;
	localparam logic [15:0] RESET_ADDR    = 16'h0000;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0]
	{
		TLIP_LV_L0  = 2'b00,
		TLIP_LV_L1  = 2'b01,
		TLIP_LV_NMI = 2'b10
	} tlip_level_type;

	// Gray along hold -> armed -> vect; vect -> hold flips both bits
	typedef enum logic [1:0]
	{
		TLIP_ST_HOLD  = 2'b00,
		TLIP_ST_ARMED = 2'b01,
		TLIP_ST_VECT  = 2'b11
	} tlip_state_type;

	typedef struct packed
	{
		logic           valid;
		tlip_level_type level;
		logic [7:0]     vnum;
	} tlip_grant_type;

endpackage

// File: sim/testbench.sv
// Self-checking testbench for the two-level interrupt prioritizer
`timescale 1ns/1ps
module testbench;
	import tlip_pkg::*;
	localparam logic [15:0] APP = 16'h0100;
	localparam logic [15:0] OFS = 16'h0040;
	localparam logic [15:0] B0  = APP + OFS;
	int          n_errors = 0;
	int          checked  = 0;
	logic        clk_sys = 1'b0;
	logic        rst_n, ce, dbg_halt, nmi_req, gie, insn_done, irq_ret;
	logic        reg_wr, reg_rd, vec_load, exec_en, ret_req;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, ack_vnum, level_status;
	logic [15:0] vec_addr, irq_req, set_f, clr_f, int_en;

	always #5 clk_sys = ~clk_sys;

	tlip_arbiter #(.NUM_IRQ(16), .APP_START(APP), .VEC_OFFSET(OFS), .VEC_WORDS(2)) u_dut
	(
		.CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce), .DBG_HALT(dbg_halt),
		.IRQ_REQ(irq_req), .NMI_REQ(nmi_req), .GIE(gie), .INSN_DONE(insn_done),
		.IRQ_RET(irq_ret), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_RDATA(reg_rdata), .VEC_LOAD(vec_load),
		.VEC_ADDR(vec_addr), .ACK_VNUM(ack_vnum), .LEVEL_STATUS(level_status)
	);
	tlip_core_model #(.N(16)) u_core
	(
		.clk(clk_sys), .rst_n(rst_n), .exec_en(exec_en), .ret_req(ret_req),
		.set_f(set_f), .clr_f(clr_f), .int_en(int_en), .insn_done(insn_done),
		.irq_ret(irq_ret), .irq_req(irq_req)
	);

	// ****
	// Compare and bus tasks
	// ****
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1;
		cmp8(reg_rdata, exp);
	endtask
	task automatic flag(input logic [15:0] s, input logic [15:0] c);
		@(posedge clk_sys);
		set_f <= s;
		clr_f <= c;
		@(posedge clk_sys);
		set_f <= '0;
		clr_f <= '0;
	endtask
	task automatic ret();
		@(posedge clk_sys);
		ret_req <= 1'b1;
		@(posedge clk_sys);
		ret_req <= 1'b0;
	endtask
	// Bounded wait so a missing entry cannot hang the run
	task automatic wait_load();
		int i;
		i = 0;
		do
		begin
			@(posedge clk_sys);
			#1;
			i++;
		end
		while (vec_load !== 1'b1 && i < 40);
		cmp8({7'h00, vec_load}, 8'h01);
	endtask
	task automatic entry(input logic [7:0] v, input logic [15:0] a, input logic [7:0] s);
		wait_load();
		cmp8(ack_vnum, v);
		cmp16(vec_addr, a);
		cmp8(level_status, s);
	endtask
	task automatic quiet(input int n);
		repeat (n)
		begin
			@(posedge clk_sys);
			#1;
			cmp8({7'h00, vec_load}, 8'h00);
		end
	endtask
	task automatic wrap_up();
		if (n_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ****
	// Watchdog
	// ****
	initial
	begin
		#300000;
		n_errors++;
		wrap_up();
	end

	// ****
	// Main sequence
	// ****
	initial
	begin
		{rst_n, dbg_halt, nmi_req, gie, reg_wr, reg_rd, exec_en, ret_req} = '0;
		ce = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		{set_f, clr_f} = '0;
		int_en = '1;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		cmp16(vec_addr, RESET_ADDR);
		rd(OFS_CTL_A, CTL_A_RST);
		rd(OFS_STATUS, STATUS_RST);
		rd(OFS_HPVEC, HPVEC_RST);
		rd(4'h9, RDATA_IDLE);
		@(posedge clk_sys);
		exec_en <= 1'b1;
		flag(16'h0012, 16'h0000);
		quiet(8);
		@(posedge clk_sys);
		gie <= 1'b1;
		entry(8'h02, B0 + 16'h0004, 8'h01);
		quiet(6);
		flag(16'h0000, 16'h0002);
		ret();
		entry(8'h05, B0 + 16'h000a, 8'h01);
		wr(OFS_HPVEC, 8'h06);
		flag(16'h0020, 16'h0000);
		entry(8'h06, B0 + 16'h000c, 8'h03);
		flag(16'h0000, 16'h0020);
		ret();
		quiet(4);
		rd(OFS_STATUS, 8'h01);
		ret();
		entry(8'h05, B0 + 16'h000a, 8'h01);
		flag(16'h0000, 16'h0010);
		ret();
		quiet(4);
		rd(OFS_STATUS, 8'h00);
		@(posedge clk_sys);
		gie     <= 1'b0;
		nmi_req <= 1'b1;
		entry(VEC_NMI, B0, 8'h80);
		@(posedge clk_sys);
		nmi_req <= 1'b0;
		gie     <= 1'b1;
		ret();
		@(posedge clk_sys);
		dbg_halt <= 1'b1;
		flag(16'h0001, 16'h0000);
		quiet(6);
		@(posedge clk_sys);
		dbg_halt <= 1'b0;
		ce       <= 1'b0;
		quiet(4);
		@(posedge clk_sys);
		ce <= 1'b1;
		entry(8'h01, B0 + 16'h0002, 8'h01);
		flag(16'h0000, 16'h0001);
		ret();
		wr(OFS_CTL_A, 8'h60);
		rd(OFS_CTL_A, 8'h60);
		flag(16'h0080, 16'h0000);
		entry(8'h08, OFS + 16'h0004, 8'h01);
		flag(16'h0000, 16'h0080);
		ret();
		wr(OFS_STATUS, 8'hff);
		rd(OFS_STATUS, 8'h00);
		rd(OFS_LVL0PRI, 8'h07);
		// Both flags stay up so the first two returns reopen the same contest
		wr(OFS_CTL_A, 8'h01);
		flag(16'h0005, 16'h0000);
		entry(8'h01, B0 + 16'h0002, 8'h01);
		ret();
		entry(8'h03, B0 + 16'h0006, 8'h01);
		ret();
		entry(8'h01, B0 + 16'h0002, 8'h01);
		flag(16'h0000, 16'h0005);
		ret();
		quiet(4);
		@(posedge clk_sys);
		int_en <= 16'hfffe;
		flag(16'h0001, 16'h0000);
		quiet(6);
		flag(16'h0000, 16'h0001);
		wrap_up();
	end
endmodule

// File: sim/tlip_core_model.sv
// Partner model: processor core retiring instructions plus peripheral flag sources
`timescale 1ns/1ps
module tlip_core_model
#(
	parameter int N = 16
)
(
	input  wire logic         clk,       // System clock
	input  wire logic         rst_n,     // Reset, active low
	input  wire logic         exec_en,   // Core is running code
	input  wire logic         ret_req,   // Handler ends with a return
	input  wire logic [N-1:0] set_f,     // Interrupt conditions occurring
	input  wire logic [N-1:0] clr_f,     // Software clearing of flags
	input  wire logic [N-1:0] int_en,    // Source enables
	output logic              insn_done, // One instruction retired
	output logic              irq_ret,   // Return instruction executed
	output logic      [N-1:0] irq_req    // Request levels to the controller
);
	logic [N-1:0] flag_r;

	// ****
	// Peripheral flags
	// ****
	// Flags only fall on an explicit clear, never on service
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			flag_r <= '0;
		else
			flag_r <= (flag_r | set_f) & ~clr_f;
	end
	assign irq_req = flag_r & int_en;

	// ****
	// Core
	// ****
	// A return also counts as a retired instruction
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			insn_done <= 1'b0;
			irq_ret   <= 1'b0;
		end
		else
		begin
			insn_done <= exec_en | ret_req;
			irq_ret   <= ret_req;
		end
	end
endmodule

// File: src/tlip_arbiter.sv
// Two-level interrupt prioritizer sitting between peripheral requests and the core
`timescale 1ns/1ps
// Overview of operation
// (R1) Two maskable levels: 0 normal, 1 high
// (R2) Acknowledge only with priority, else keep pending
// (R3) Acknowledge loads program counter with vector
// (R4) One instruction runs before serving any interrupt
// (R5) Track active levels; return restores earlier level
// (R6) Level status never saved automatically on acknowledge
// (R7) All requests level 0 after reset
// (R8) Level 1 preempts running level 0 handler
// (R9) Fixed mode: lowest vector address wins
// (R10) Round-robin bounds wait of level 0 requests
// (R11) Maskable requests served only when global enable set
// (R12) Acknowledge leaves global enable untouched
// (R13) Software writes global enable to block/allow
// (R14) Requests come only from enabled, triggered sources
// (R15) Peripheral flags stay set after service
// (R16) Reset address zero; section select places vectors
// (R17) Software configures controller, peripheral, then global enable
// (R18) Control register holds section and compact bits
// (R19) Round-robin enable bit selects rotating scheme
// (R20) Vector named in high-priority register is level 1
// (R21) Non-maskable requests ignore enable, rank highest
// (R22) Halted debug stops the controller; run-time continues
// (R23) Request stays up until flag cleared
// (R24) Last acknowledged level 0 vector ranks lowest next

module tlip_arbiter
	import tlip_pkg::*;
#(
	parameter int          NUM_IRQ    = 16,
	parameter logic [15:0] APP_START  = 16'h0000,
	parameter logic [15:0] VEC_OFFSET = 16'h0000,
	parameter int          VEC_WORDS  = 2
)
(
	input  wire logic              CLK_SYS,     // System clock, 100 MHz
	input  wire logic              RST_N,       // Asynchronous reset, active low
	input  wire logic              CE,          // Clock enable, freezes all state except the reset synchronizer when low
	input  wire logic              DBG_HALT,    // Core halted by debugger
	input  wire logic [NUM_IRQ-1:0] IRQ_REQ,    // Peripheral request levels
	input  wire logic              NMI_REQ,     // Non-maskable request level
	input  wire logic              GIE,         // Global enable bit of status register
	input  wire logic              INSN_DONE,   // Core retired one instruction
	input  wire logic              IRQ_RET,     // Core executed interrupt return
	input  wire logic [ADDR_W-1:0] REG_ADDR,    // Register address
	input  wire logic [DATA_W-1:0] REG_WDATA,   // Register write data
	input  wire logic              REG_WR,      // Register write strobe
	input  wire logic              REG_RD,      // Register read strobe
	output logic      [DATA_W-1:0] REG_RDATA,   // Read data, cycle after strobe
	output logic                   VEC_LOAD,    // Program counter load pulse
	output logic      [PC_W-1:0]   VEC_ADDR,    // Vector address for program counter
	output logic      [VNUM_W-1:0] ACK_VNUM,    // Vector number acknowledged
	output logic      [DATA_W-1:0] LEVEL_STATUS // Active level flags
);

	localparam int IDX_W = (NUM_IRQ > 1) ? $clog2(NUM_IRQ) : 1;

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic rst_meta_r;
	logic rst_n_s;

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rst_meta_r <= 1'b0;
			rst_n_s    <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n_s    <= rst_meta_r;
		end
	end

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [7:0]           ctl_a_r;
	logic [7:0]           status_r;
	logic [7:0]           hpvec_r;
	logic [IDX_W-1:0]     last_r;
	tlip_state_type       st_r;
	tlip_grant_type       grant;
	logic                 run;
	logic                 take;
	logic                 hp_ok;
	logic [IDX_W-1:0]     hp_idx;
	logic [NUM_IRQ-1:0]   hp_mask;
	logic [NUM_IRQ-1:0]   lo_req;
	logic                 lo_hit;
	logic [IDX_W-1:0]     fix_idx;
	logic [IDX_W-1:0]     rr_idx;
	logic [IDX_W-1:0]     pick_idx;
	logic [7:0]           slot;
	logic [PC_W-1:0]      vec_base;
	logic [PC_W-1:0]      addr_nxt;
	logic [7:0]           status_nxt;

	// Halted debug freezes arbitration but leaves the register port usable
	assign run = CE && !DBG_HALT; // R22

	// ****************************************************************
	// Request qualification
	// ****************************************************************
	// Lines are levels held by the peripherals until their flags clear;
	// nothing here ever clears a source flag.
	always_comb
	begin
		hp_ok   = (hpvec_r >= VEC_FIRST) && (32'(hpvec_r) < 32'(VEC_FIRST) + NUM_IRQ); // R20
		hp_idx  = IDX_W'(hpvec_r - VEC_FIRST);
		hp_mask = '0;
		if (hp_ok)
			hp_mask[hp_idx] = 1'b1; // R7 R20
		lo_req = IRQ_REQ & ~hp_mask; // R14 R15 R23
	end

	// ****************************************************************
	// Level 0 arbitration
	// ****************************************************************
	always_comb
	begin
		int j;
		j       = 0;
		lo_hit  = 1'b0;
		fix_idx = '0;
		rr_idx  = '0;
		for (int i = NUM_IRQ - 1; i >= 0; i--)
		begin
			if (lo_req[i])
			begin
				lo_hit  = 1'b1;
				fix_idx = IDX_W'(i); // R9
			end
		end
		// Walk backwards so the slot just after the last winner is taken
		for (int k = NUM_IRQ; k >= 1; k--)
		begin
			j = (int'(last_r) + k) % NUM_IRQ;
			if (lo_req[j])
				rr_idx = IDX_W'(j); // R10 R24
		end
		pick_idx = ctl_a_r[CTL_A_RR_BIT] ? rr_idx : fix_idx; // R19
	end

	// ****************************************************************
	// Level arbitration
	// ****************************************************************
	always_comb
	begin
		grant = '{valid: 1'b0, level: TLIP_LV_L0, vnum: VEC_NMI};
		if (NMI_REQ && !status_r[STAT_NMI_BIT])
			grant = '{valid: 1'b1, level: TLIP_LV_NMI, vnum: VEC_NMI}; // R21
		else if (!status_r[STAT_NMI_BIT] && GIE && hp_ok && IRQ_REQ[hp_idx]
			&& !status_r[STAT_LVL1_BIT])
			grant = '{valid: 1'b1, level: TLIP_LV_L1, vnum: hpvec_r}; // R8 R11
		else if (!status_r[STAT_NMI_BIT] && GIE && !status_r[STAT_LVL1_BIT]
			&& !status_r[STAT_LVL0_BIT] && lo_hit)
			grant = '{valid: 1'b1, level: TLIP_LV_L0,
				vnum: VNUM_W'(pick_idx) + VEC_FIRST}; // R1 R2 R11
	end

	assign take = run && (st_r == TLIP_ST_ARMED) && grant.valid; // R2

	// ****************************************************************
	// Vector placement
	// ****************************************************************
	always_comb
	begin
		vec_base = ctl_a_r[CTL_A_SECT_BIT] ? VEC_OFFSET : APP_START + VEC_OFFSET; // R16
		slot     = grant.vnum;
		if (ctl_a_r[CTL_A_COMPACT_BIT])
		begin
			// Compact table: one shared entry per level
			case (grant.level)
				TLIP_LV_NMI: slot = CVT_SLOT_NMI;
				TLIP_LV_L1:  slot = CVT_SLOT_LVL1;
				default:     slot = CVT_SLOT_LVL0;
			endcase // R18
		end
		addr_nxt = vec_base + PC_W'(slot) * PC_W'(VEC_WORDS);
	end

	// ****************************************************************
	// Instruction gate
	// ****************************************************************
	// A return also needs one following instruction before a new entry
	always_ff @(posedge CLK_SYS or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			st_r <= TLIP_ST_HOLD;
		end
		else if (run)
		begin
			case (st_r)
				TLIP_ST_HOLD:
				begin
					if (INSN_DONE && !IRQ_RET)
						st_r <= TLIP_ST_ARMED; // R4
				end
				TLIP_ST_ARMED:
				begin
					if (grant.valid)
						st_r <= TLIP_ST_VECT;
					else if (IRQ_RET)
						st_r <= TLIP_ST_HOLD; // R4
				end
				default:
					st_r <= TLIP_ST_HOLD; // R4
			endcase
		end
	end

	// ****************************************************************
	// Active level tracking
	// ****************************************************************
	// Only the innermost level drops on return; no copy is pushed anywhere,
	// software saves the status itself if it ever needs to.
	always_comb
	begin
		status_nxt = status_r;
		if (IRQ_RET)
		begin
			if (status_r[STAT_NMI_BIT])
				status_nxt[STAT_NMI_BIT] = 1'b0; // R5
			else if (status_r[STAT_LVL1_BIT])
				status_nxt[STAT_LVL1_BIT] = 1'b0; // R5
			else
				status_nxt[STAT_LVL0_BIT] = 1'b0; // R5
		end
		if (take)
		begin
			case (grant.level)
				TLIP_LV_NMI: status_nxt[STAT_NMI_BIT]  = 1'b1;
				TLIP_LV_L1:  status_nxt[STAT_LVL1_BIT] = 1'b1;
				default:     status_nxt[STAT_LVL0_BIT] = 1'b1;
			endcase // R6
		end
	end

	always_ff @(posedge CLK_SYS or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			status_r     <= STATUS_RST;
			LEVEL_STATUS <= STATUS_RST;
		end
		else if (run)
		begin
			status_r     <= status_nxt; // R5
			LEVEL_STATUS <= status_nxt;
		end
	end

	always_ff @(posedge CLK_SYS or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			last_r <= '0;
		end
		else if (take && grant.level == TLIP_LV_L0)
		begin
			last_r <= pick_idx; // R24
		end
	end

	// ****************************************************************
	// Program counter redirect
	// ****************************************************************
	// Global enable is only read here; it is the core's to change
	always_ff @(posedge CLK_SYS or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			VEC_LOAD <= 1'b0;
			VEC_ADDR <= RESET_ADDR; // R16
			ACK_VNUM <= VEC_NMI;
		end
		else if (CE)
		begin
			VEC_LOAD <= take; // R3 R12
			if (take)
			begin
				VEC_ADDR <= addr_nxt; // R3
				ACK_VNUM <= grant.vnum;
			end
		end
	end

	// ****************************************************************
	// Register port
	// ****************************************************************
	always_ff @(posedge CLK_SYS or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			ctl_a_r <= CTL_A_RST;
			hpvec_r <= HPVEC_RST; // R7
		end
		else if (CE && REG_WR)
		begin
			if (REG_ADDR == OFS_CTL_A)
			begin
				ctl_a_r <= REG_WDATA; // R18 R19
			end
			else if (REG_ADDR == OFS_HPVEC)
			begin
				hpvec_r <= REG_WDATA; // R20
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			REG_RDATA <= RDATA_IDLE;
		end
		else if (CE)
		begin
			REG_RDATA <= RDATA_IDLE;
			if (REG_RD)
			begin
				if (REG_ADDR == OFS_CTL_A)
				begin
					REG_RDATA <= ctl_a_r;
				end
				else if (REG_ADDR == OFS_STATUS)
				begin
					REG_RDATA <= status_r;
				end
				else if (REG_ADDR == OFS_LVL0PRI)
				begin
					REG_RDATA <= DATA_W'(last_r);
				end
				else if (REG_ADDR == OFS_HPVEC)
				begin
					REG_RDATA <= hpvec_r;
				end
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!rst_n_s);

	AST_GIE_GATES: assert property (take && grant.level != TLIP_LV_NMI |-> GIE) // R11
		else $error("maskable request served with global enable low");
	AST_LOAD_FOLLOWS: assert property (take |=> VEC_LOAD && VEC_ADDR == $past(addr_nxt)) // R3
		else $error("vector load missing or wrong address");
	AST_ONE_INSN: assert property (VEC_LOAD |-> !take) // R4
		else $error("second entry without an instruction between");
	AST_HOLD_NEEDS_INSN: assert property (st_r == TLIP_ST_HOLD && !INSN_DONE // R4
		|=> st_r != TLIP_ST_ARMED)
		else $error("armed without an executed instruction");
	AST_RET_NMI: assert property (run && IRQ_RET && !take && status_r[STAT_NMI_BIT] // R5
		|=> !status_r[STAT_NMI_BIT] && status_r[STAT_LVL1_BIT] == $past(status_r[STAT_LVL1_BIT]))
		else $error("return did not restore the earlier level");
	AST_L0_NESTING: assert property (take && grant.level == TLIP_LV_L0 // R2
		|-> status_r == STATUS_RST)
		else $error("level 0 entered while a handler is active");
	AST_FIXED_LOWEST: assert property (take && grant.level == TLIP_LV_L0 // R9
		&& !ctl_a_r[CTL_A_RR_BIT] |-> (lo_req & ((NUM_IRQ'(1) << pick_idx) - NUM_IRQ'(1))) == '0)
		else $error("fixed mode did not pick lowest vector");
	AST_RR_LAST: assert property (take && grant.level == TLIP_LV_L0 // R24
		|=> last_r == $past(pick_idx))
		else $error("round-robin pointer not updated");
	AST_HP_VECTOR: assert property (take && grant.level == TLIP_LV_L1 // R20
		|-> grant.vnum == hpvec_r && IRQ_REQ[hp_idx])
		else $error("level 1 granted to another vector");
	AST_NMI_FIRST: assert property (run && st_r == TLIP_ST_ARMED && NMI_REQ // R21
		&& !status_r[STAT_NMI_BIT] |-> take && grant.level == TLIP_LV_NMI)
		else $error("pending non-maskable request not served first");
	AST_HALT_FREEZE: assert property (DBG_HALT |-> !take ##1 $stable(status_r)) // R22
		else $error("controller moved while halted");
	COV_L1_PREEMPT: cover property (status_r[STAT_LVL0_BIT] && take && grant.level == TLIP_LV_L1);
	COV_RR_ENTRY: cover property (take && ctl_a_r[CTL_A_RR_BIT] && grant.level == TLIP_LV_L0);
	COV_NMI_ENTRY: cover property (take && grant.level == TLIP_LV_NMI && !GIE);
	COV_RETURN: cover property (IRQ_RET && status_r[STAT_LVL1_BIT] ##1 status_r[STAT_LVL0_BIT]);

endmodule
